/* File: dctc_pkg.sv */
// Purpose: constants for the three-channel down-counting timer with capture on channel 2
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: register offsets are byte addresses, each register one aligned word
package dctc_pkg;
    localparam int NUM_CH = 3;
    localparam int PRE_W = 8;

    localparam logic [7:0] ADDR_RUN = 8'h00;
    localparam logic [7:0] ADDR_CAPTURE = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CH_BASE = 8'h10;
    localparam logic [7:0] ADDR_CH_STRIDE = 8'h10;
    localparam logic [1:0] SUB_CTRL = 2'h0;
    localparam logic [1:0] SUB_RELOAD = 2'h1;
    localparam logic [1:0] SUB_COUNT = 2'h2;

    // Control register layout
    localparam int CTL_CLK_LSB = 0;
    localparam int CTL_EDGE_LSB = 3;
    localparam int CTL_UIE_BIT = 5;
    localparam int CTL_CAPM_LSB = 6;
    localparam int CTL_UFL_BIT = 8;
    localparam int CTL_CAPF_BIT = 9;
    localparam int CTL_W = 10;

    localparam logic [2:0] CLK_DIV4 = 3'h0;
    localparam logic [2:0] CLK_DIV16 = 3'h1;
    localparam logic [2:0] CLK_DIV64 = 3'h2;
    localparam logic [2:0] CLK_DIV256 = 3'h3;
    localparam logic [2:0] CLK_EXT = 3'h5;

    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    localparam logic [1:0] CAPM_OFF = 2'h0;
    localparam logic [1:0] CAPM_IRQ = 2'h3;

    // Interrupt status and mask bit positions
    localparam int IRQ_UFL0 = 0;
    localparam int IRQ_CAP = 3;
    localparam int IRQ_W = 4;

    localparam logic [31:0] RELOAD_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] COUNT_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] CAPTURE_RST = 32'h0000_0000;

    // Least pin level hold, in module clock cycles, for the external source
    localparam int PIN_HOLD_SINGLE = 2;
    localparam int PIN_HOLD_BOTH = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: dctc_timer.sv */
// Purpose: three-channel down-counting timer, capture on channel 2, AXI4-Lite slave
// Assumes: pin and standby inputs synchronous to clock; software halts a channel to write it
// Notes: one write and one read in flight at most; read answers come one cycle after acceptance, write answers two
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module dctc_timer #(
    parameter int CNT_W = 32,
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_timer_clock_pin,
    input wire logic standby,
    output logic irq,
    output logic channel0_underflow_irq,
    output logic channel1_underflow_irq,
    output logic channel2_underflow_irq,
    output logic channel2_capture_irq,
    output logic [1:0] irq_top_source,
    output logic irq_top_valid
);
    import dctc_pkg::*;

    if (CNT_W < 1 || CNT_W > 32 || ADDR_W < 8) begin : g_bad_param
        $error("CNT_W must be 1 to 32, ADDR_W at least 8");
    end

    typedef logic [CNT_W-1:0] dctc_cnt_t;
    typedef logic [CTL_W-1:0] dctc_ctl_t;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic div_tick(input logic [2:0] src, input logic [PRE_W-1:0] pre);
        logic t;
        t = 1'b0;
        unique case (src)
            CLK_DIV4: t = &pre[1:0];
            CLK_DIV16: t = &pre[3:0];
            CLK_DIV64: t = &pre[5:0];
            CLK_DIV256: t = &pre[7:0];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        logic h;
        if (sel[1]) begin
            h = rise | fall;
        end else if (sel == EDGE_FALL) begin
            h = fall;
        end else begin
            h = rise;
        end
        return h;
    endfunction

    // Register state
    dctc_ctl_t ctrl [NUM_CH];
    dctc_ctl_t next_ctrl [NUM_CH];
    dctc_cnt_t reload [NUM_CH];
    dctc_cnt_t next_reload [NUM_CH];
    dctc_cnt_t count [NUM_CH];
    dctc_cnt_t next_count [NUM_CH];
    logic [NUM_CH-1:0] run, next_run;
    dctc_cnt_t capture, next_capture;
    logic [IRQ_W-1:0] irq_status, next_irq_status;
    logic [IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [PRE_W-1:0] prescale, next_prescale;
    logic pin_q, next_pin_q;

    // Bus state
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // Interrupt outputs
    logic next_irq, next_uirq0, next_uirq1, next_uirq2, next_cirq, next_top_valid;
    logic [1:0] next_top_source;

    always_comb begin
        logic rise, fall, tick, do_write, do_read, wr_ok, rd_ok, cap_hit, status_rd;
        logic [7:0] ra;
        logic [IRQ_W-1:0] events;
        logic [31:0] merged;
        logic [NUM_CH:0] req;
        int rch, wch;
        rise = external_timer_clock_pin & ~pin_q;
        fall = ~external_timer_clock_pin & pin_q;
        tick = 1'b0;
        do_write = 1'b0;
        do_read = 1'b0;
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        cap_hit = 1'b0;
        status_rd = 1'b0;
        ra = 8'h00;
        events = '0;
        merged = 32'h0000_0000;
        req = '0;
        rch = 0;
        wch = 0;
        for (int c = 0; c < NUM_CH; c++) begin
            next_ctrl[c] = ctrl[c];
            next_reload[c] = reload[c];
            next_count[c] = count[c];
        end
        next_run = run;
        next_capture = capture;
        next_irq_mask = irq_mask;
        next_prescale = prescale + 1'b1;
        next_pin_q = external_timer_clock_pin;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;

        // Counting
        for (int c = 0; c < NUM_CH; c++) begin
            if (ctrl[c][CTL_CLK_LSB +: 3] == CLK_EXT) begin
                tick = edge_hit(ctrl[c][CTL_EDGE_LSB +: 2], rise, fall);
            end else begin
                tick = div_tick(ctrl[c][CTL_CLK_LSB +: 3], prescale);
            end
            if (run[c] && tick) begin
                if (count[c] == '0) begin
                    next_count[c] = reload[c];
                    next_ctrl[c][CTL_UFL_BIT] = 1'b1;
                    events[IRQ_UFL0 + c] = 1'b1;
                end else begin
                    next_count[c] = count[c] - 1'b1;
                end
            end
        end

        // Capture only on channel 2; mode 01 is treated as off
        cap_hit = ctrl[2][CTL_CAPM_LSB + 1] && !standby
                  && edge_hit(ctrl[2][CTL_EDGE_LSB +: 2], rise, fall);
        if (cap_hit) begin
            next_capture = count[2];
            next_ctrl[2][CTL_CAPF_BIT] = 1'b1;
            events[IRQ_CAP] = 1'b1;
        end

        // Write channels: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
        end
        do_write = aw_held && w_held && !s_axi_bvalid;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            wr_ok = 1'b1;
            if (wr_addr == ADDR_RUN) begin
                merged = merge_bytes(32'(run), wr_data, wr_strb);
                next_run = merged[NUM_CH-1:0];
            end else if (wr_addr == ADDR_IRQ_MASK) begin
                merged = merge_bytes(32'(irq_mask), wr_data, wr_strb);
                next_irq_mask = merged[IRQ_W-1:0];
            end else if (wr_addr >= ADDR_CH_BASE && wr_addr[3:2] != 2'h3
                         && wr_addr < ADDR_CH_BASE + NUM_CH * ADDR_CH_STRIDE) begin
                // Software stops the channel first; the write simply overrides counting
                wch = int'((wr_addr - ADDR_CH_BASE) >> 4);
                unique case (wr_addr[3:2])
                    SUB_CTRL: begin
                        merged = merge_bytes(32'(ctrl[wch]), wr_data, wr_strb);
                        next_ctrl[wch][CTL_CAPM_LSB-1:0] = merged[CTL_CAPM_LSB-1:0];
                        if (wch == 2) begin
                            next_ctrl[wch][CTL_CAPM_LSB +: 2] = merged[CTL_CAPM_LSB +: 2];
                        end
                        // Hardware set wins over a written 0 in the same cycle
                        if (wr_strb[1]) begin
                            next_ctrl[wch][CTL_UFL_BIT] = next_ctrl[wch][CTL_UFL_BIT]
                                & (wr_data[CTL_UFL_BIT] | events[IRQ_UFL0 + wch]);
                            if (wch == 2) begin
                                next_ctrl[wch][CTL_CAPF_BIT] = next_ctrl[wch][CTL_CAPF_BIT]
                                    & (wr_data[CTL_CAPF_BIT] | cap_hit);
                            end
                        end
                    end
                    SUB_RELOAD: begin
                        merged = merge_bytes(32'(reload[wch]), wr_data, wr_strb);
                        next_reload[wch] = merged[CNT_W-1:0];
                    end
                    default: begin
                        merged = merge_bytes(32'(count[wch]), wr_data, wr_strb);
                        next_count[wch] = merged[CNT_W-1:0];
                    end
                endcase
            end else begin
                wr_ok = 1'b0;
            end
            next_bvalid = 1'b1;
            next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end

        // Read channel: data is taken from registers before this edge's decrement
        do_read = s_axi_arvalid && s_axi_arready;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (do_read) begin
            ra = s_axi_araddr[7:0];
            rd_ok = 1'b1;
            next_rdata = 32'h0000_0000;
            if (ra == ADDR_RUN) begin
                next_rdata = 32'(run);
            end else if (ra == ADDR_CAPTURE) begin
                next_rdata = 32'(capture);
            end else if (ra == ADDR_IRQ_STATUS) begin
                next_rdata = 32'(irq_status);
                status_rd = 1'b1;
            end else if (ra == ADDR_IRQ_MASK) begin
                next_rdata = 32'(irq_mask);
            end else if (ra >= ADDR_CH_BASE && ra[3:2] != 2'h3
                         && ra < ADDR_CH_BASE + NUM_CH * ADDR_CH_STRIDE) begin
                rch = int'((ra - ADDR_CH_BASE) >> 4);
                unique case (ra[3:2])
                    SUB_CTRL: next_rdata = 32'(ctrl[rch]);
                    SUB_RELOAD: next_rdata = 32'(reload[rch]);
                    default: next_rdata = 32'(count[rch]);
                endcase
            end else begin
                rd_ok = 1'b0;
            end
            next_rvalid = 1'b1;
            next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // Sticky status cleared by read; a new event in that cycle survives
        next_irq_status = (status_rd ? '0 : irq_status) | events;
        next_irq = |(next_irq_status & next_irq_mask);

        // Per-source requests: flag and its enable both set
        for (int c = 0; c < NUM_CH; c++) begin
            req[c] = next_ctrl[c][CTL_UFL_BIT] & next_ctrl[c][CTL_UIE_BIT];
        end
        req[NUM_CH] = next_ctrl[2][CTL_CAPF_BIT]
                      & (next_ctrl[2][CTL_CAPM_LSB +: 2] == CAPM_IRQ);
        next_uirq0 = req[0];
        next_uirq1 = req[1];
        next_uirq2 = req[2];
        next_cirq = req[NUM_CH];

        // Fixed priority: lowest index wins
        next_top_valid = |req;
        next_top_source = 2'h0;
        for (int s = NUM_CH; s >= 0; s--) begin
            if (req[s]) begin
                next_top_source = 2'(s);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                ctrl[c] <= '0;
                reload[c] <= RELOAD_RST[CNT_W-1:0];
                count[c] <= COUNT_RST[CNT_W-1:0];
            end
            run <= '0;
            capture <= CAPTURE_RST[CNT_W-1:0];
            irq_status <= '0;
            irq_mask <= '0;
            prescale <= '0;
            pin_q <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            irq <= 1'b0;
            channel0_underflow_irq <= 1'b0;
            channel1_underflow_irq <= 1'b0;
            channel2_underflow_irq <= 1'b0;
            channel2_capture_irq <= 1'b0;
            irq_top_source <= 2'h0;
            irq_top_valid <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            reload <= next_reload;
            count <= next_count;
            run <= next_run;
            capture <= next_capture;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            prescale <= next_prescale;
            pin_q <= next_pin_q;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            irq <= next_irq;
            channel0_underflow_irq <= next_uirq0;
            channel1_underflow_irq <= next_uirq1;
            channel2_underflow_irq <= next_uirq2;
            channel2_capture_irq <= next_cirq;
            irq_top_source <= next_top_source;
            irq_top_valid <= next_top_valid;
            // Ready flops: one item per channel until its response is accepted
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
            s_axi_arready <= !next_rvalid;
        end
    end
endmodule

/* File: dctc_timer_checker.sv */
// Purpose: port-level checks for the down-counting timer
// Assumes: one clock, synchronous active-high reset
// Notes: flags are internal, so checks lean on interrupt outputs and bus answers
module dctc_timer_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_timer_clock_pin,
    input wire logic standby,
    input wire logic irq,
    input wire logic channel0_underflow_irq,
    input wire logic channel1_underflow_irq,
    input wire logic channel2_underflow_irq,
    input wire logic channel2_capture_irq,
    input wire logic [1:0] irq_top_source,
    input wire logic irq_top_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_top_ch0;
        channel0_underflow_irq |-> irq_top_valid && irq_top_source == 2'h0;
    endproperty
    a_top_ch0: assert property (p_top_ch0)
        else $error("top source not channel 0");
    property p_top_cap;
        irq_top_valid && irq_top_source == 2'h3 |-> channel2_capture_irq
            && !channel0_underflow_irq && !channel1_underflow_irq && !channel2_underflow_irq;
    endproperty
    a_top_cap: assert property (p_top_cap)
        else $error("capture chosen over an underflow");
    property p_top_valid;
        irq_top_valid == (channel0_underflow_irq || channel1_underflow_irq
            || channel2_underflow_irq || channel2_capture_irq);
    endproperty
    a_top_valid: assert property (p_top_valid)
        else $error("summary disagrees with sources");
    // A flag only drops through a register write
    property p_flag_fall;
        $fell(channel0_underflow_irq) |-> s_axi_bvalid;
    endproperty
    a_flag_fall: assert property (p_flag_fall)
        else $error("underflow request dropped without a write");
    property p_irq_fall;
        $fell(irq) |-> s_axi_rvalid || s_axi_bvalid;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without a bus access");
    property p_standby;
        $rose(channel2_capture_irq) |-> !$past(standby) || s_axi_bvalid;
    endproperty
    a_standby: assert property (p_standby)
        else $error("capture during standby");
    property p_cap_edge;
        $rose(channel2_capture_irq) && !s_axi_bvalid |->
            external_timer_clock_pin != $past(external_timer_clock_pin)
            || $past(external_timer_clock_pin) != $past(external_timer_clock_pin, 2)
            || $past(external_timer_clock_pin, 2) != $past(external_timer_clock_pin, 3);
    endproperty
    a_cap_edge: assert property (p_cap_edge)
        else $error("capture without a pin edge");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data not held");
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans)
        else $error("write answer late");

    c_cap: cover property ($rose(channel2_capture_irq));
    c_top1: cover property (irq_top_source == 2'h1);
    c_irq_fall: cover property ($fell(irq));
endmodule
bind dctc_timer dctc_timer_checker i_chk (.*);

/* File: dctc_timer_tb.sv */
// Purpose: self-checking bench for the down-counting timer
// Assumes: AXI4-Lite master in the bench, pin driven with 4-cycle levels
// Notes: timing checks use a tick range, the prescaler phase is free
module dctc_timer_tb;
    import dctc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic external_timer_clock_pin, standby, irq, irq_top_valid;
    logic channel0_underflow_irq, channel1_underflow_irq, channel2_underflow_irq;
    logic channel2_capture_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, x, cap, v, ctl, f;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_top_source, r;
    int errors = 0, check_count = 0, cyc = 0, seed, t0, t1, lo;

    dctc_timer i_dut (.clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_timer_clock_pin, .standby, .irq,
        .channel0_underflow_irq, .channel1_underflow_irq, .channel2_underflow_irq,
        .channel2_capture_irq, .irq_top_source, .irq_top_valid);

    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    // Ceiling far above the run's length
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] rng(input logic [31:0] s, input int lo, input int hi);
        return (s >= 32'(lo) && s <= 32'(hi)) ? 32'(lo) : s;
    endfunction
    function automatic logic [7:0] ca(input int c, input logic [1:0] s);
        return ADDR_CH_BASE + ADDR_CH_STRIDE * 8'(c) + {4'h0, s, 2'b00};
    endfunction
    // Trailing edge keeps requests spaced
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        dat = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] dat;
        logic [1:0] rs;
        rd(a, dat, rs);
        chk(n, dat, e);
    endtask
    // Four-cycle levels exceed both minimum widths
    task automatic pulses(input int p);
        repeat (p) begin
            external_timer_clock_pin <= 1'b1;
            repeat (4) @(posedge clock);
            external_timer_clock_pin <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask

    initial begin
        seed = 14808;
        srst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        external_timer_clock_pin = 1'b0;
        standby = 1'b0;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        wr(ADDR_CAPTURE, 32'h0000_0001);
        chk("ro write", r, RESP_SLVERR);
        rdchk(ADDR_RUN, 32'h0000_0000, "run");
        rdchk(ADDR_CAPTURE, CAPTURE_RST, "capture");
        for (int c = 0; c < 3; c++) begin
            rdchk(ca(c, SUB_RELOAD), RELOAD_RST, "reload");
            rdchk(ca(c, SUB_COUNT), COUNT_RST, "count");
            rdchk(ca(c, SUB_CTRL), 32'h0000_0000, "ctrl");
        end
        rd(8'hF0, v, r);
        chk("unmapped resp", r, RESP_SLVERR);
        chk("unmapped data", v, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wr(ca(0, SUB_COUNT), 32'h0000_1000);
            wr(ca(0, SUB_CTRL), 32'(i));
            t0 = cyc;
            wr(ADDR_RUN, 32'h0000_0001);
            repeat (512) @(posedge clock);
            t1 = cyc;
            wr(ADDR_RUN, 32'h0000_0000);
            rd(ca(0, SUB_COUNT), v, r);
            lo = (t1 - t0) / (4 << (2 * i));
            chk("ticks", rng(32'h0000_1000 - v, lo, lo + 1), 32'(lo));
            repeat (64) @(posedge clock);
            rdchk(ca(0, SUB_COUNT), v, "stopped count");
        end
        $display("divider test done");
        for (int c = 0; c < 2; c++) begin
            wr(ca(c, SUB_RELOAD), 32'h0000_0040);
            wr(ca(c, SUB_COUNT), 32'h0000_0001);
            wr(ca(c, SUB_CTRL), 32'h0000_0020);
        end
        wr(ADDR_RUN, 32'h0000_0003);
        while (!(channel0_underflow_irq && channel1_underflow_irq)) @(posedge clock);
        wr(ADDR_RUN, 32'h0000_0000);
        chk("top source", irq_top_source, 32'h0000_0000);
        rdchk(ca(0, SUB_CTRL), 32'h0000_0120, "underflow flag");
        rd(ca(0, SUB_COUNT), v, r);
        chk("reloaded", rng(32'h0000_0040 - v, 0, 8), 32'h0000_0000);
        wr(ca(0, SUB_CTRL), 32'h0000_0120);
        rdchk(ca(0, SUB_CTRL), 32'h0000_0120, "flag kept");
        chk("masked irq", irq, 32'h0000_0000);
        wr(ADDR_IRQ_MASK, 32'h0000_000F);
        chk("wr resp", r, RESP_OKAY);
        chk("irq", irq, 32'h0000_0001);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0003, "status");
        chk("irq after read", irq, 32'h0000_0000);
        wr(ca(0, SUB_CTRL), 32'h0000_0020);
        chk("ch0 request", channel0_underflow_irq, 32'h0000_0000);
        chk("top source", irq_top_source, 32'h0000_0001);
        wr(ca(1, SUB_CTRL), 32'h0000_0000);
        chk("no request", irq_top_valid, 32'h0000_0000);
        $display("underflow test done");
        for (int e = 0; e < 4; e++) begin
            ctl = 32'(CLK_EXT) | (32'(e) << CTL_EDGE_LSB) | 32'h0000_0020;
            wr(ca(2, SUB_RELOAD), 32'h0000_0003);
            wr(ca(2, SUB_COUNT), 32'h0000_0002);
            wr(ca(2, SUB_CTRL), ctl);
            wr(ADDR_RUN, 32'h0000_0004);
            pulses(3);
            wr(ADDR_RUN, 32'h0000_0000);
            v = 32'h0000_0002;
            f = 32'h0000_0000;
            repeat (e > 1 ? 6 : 3) begin
                f = f | 32'(v == 0);
                v = (v == 0) ? 32'h0000_0003 : v - 1;
            end
            rdchk(ca(2, SUB_COUNT), v, "pin count");
            rdchk(ca(2, SUB_CTRL), ctl | (f << CTL_UFL_BIT), "pin flag");
            chk("ch2 request", channel2_underflow_irq, f);
        end
        $display("pin count test done");
        cap = CAPTURE_RST;
        for (int m = 0; m < 4; m++) begin
            x = $random(seed);
            ctl = (32'(m) << CTL_CAPM_LSB) | (32'(EDGE_FALL) << CTL_EDGE_LSB);
            wr(ca(2, SUB_COUNT), x);
            wr(ca(2, SUB_CTRL), ctl);
            pulses(1);
            if (m > 1) cap = x;
            rdchk(ADDR_CAPTURE, cap, "capture");
            chk("capture irq", channel2_capture_irq, 32'(m == 3));
            if (m == 3) chk("top source", irq_top_source, 32'h0000_0003);
            rdchk(ca(2, SUB_CTRL), ctl | (32'(m > 1) << CTL_CAPF_BIT), "capture flag");
            wr(ca(2, SUB_CTRL), ctl);
            rdchk(ca(2, SUB_CTRL), ctl, "flag cleared");
        end
        standby <= 1'b1;
        wr(ca(2, SUB_CTRL), 32'(CAPM_IRQ) << CTL_CAPM_LSB);
        wr(ca(2, SUB_COUNT), ~x);
        pulses(1);
        rdchk(ADDR_CAPTURE, cap, "standby capture");
        chk("standby irq", channel2_capture_irq, 32'h0000_0000);
        standby <= 1'b0;
        wr(ca(0, SUB_CTRL), 32'h0000_00C0);
        rdchk(ca(0, SUB_CTRL), 32'h0000_0000, "ch0 capture mode");
        $display("capture test done");
        conclude();
    end
endmodule
